/* rtl/vb_pkg.sv */
// package for the value block command interpreter
package vb_pkg;
  // command codes
  localparam logic [7:0] CMD_READ_VALUE = 8'h0A;
  localparam logic [7:0] CMD_WRITE_VALUE = 8'h0B;
  // read value argument offsets
  localparam logic [3:0] RD_BLK = 4'h0;
  localparam logic [3:0] RD_BUF_OFS = 4'h1;
  localparam logic [3:0] RD_KSEL = 4'h2;
  localparam logic [3:0] RD_KEY = 4'h3;
  // write value argument offsets
  localparam logic [3:0] WR_BLK = 4'h0;
  localparam logic [3:0] WR_VAL = 4'h1;
  localparam logic [3:0] WR_ADDR = 4'h5;
  localparam logic [3:0] WR_KSEL = 4'h6;
  localparam logic [3:0] WR_KEY = 4'h7;
  // key selector fields
  localparam int KSEL_NUM_W = 6;
  localparam int KSEL_ARG_BIT = 6;
  localparam int KSEL_TYPE_BIT = 7;
  localparam logic [5:0] KEY_NUM_MAX = 6'h27;
  // result codes
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_PARSE = 8'h01;
  localparam logic [7:0] RES_AUTH = 8'h02;
  localparam logic [7:0] RES_BADCMD = 8'h03;
  localparam logic [7:0] RES_BADKEY = 8'h04;
  localparam logic [7:0] RES_RANGE = 8'h05;
  // number of value bytes plus address byte written to buffer
  localparam int RD_LEN = 5;
  typedef enum {ST_IDLE, ST_ACCESS, ST_WAIT, ST_STORE, ST_DONE} vb_state_t;
endpackage

/* rtl/vb_value_cmd.sv */
// value block read and write command interpreter
`timescale 1ns/1ns
// How it works
// - read block parsed as value plus address
// - value then address stored at offset
// - value little endian, address unsigned byte
// - write block built from value and address
// - low six bits pick key 0..39
// - top bit selects second key type
// - bit six takes key from arguments
// - argument key is least byte first
// - read uses ordinary block read sequence
// - write uses ordinary block write sequence
module vb_value_cmd
  import vb_pkg::*;
#(
  parameter int BUF_AW = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // command start
  input wire logic cmd_start_i,
  input wire logic [7:0] cmd_code_i,
  output logic cmd_busy_o,
  output logic cmd_done_o,
  output logic [7:0] cmd_result_o,
  // parameter area read port, combinational
  output logic [3:0] arg_addr_o,
  input wire logic [7:0] arg_data_i,
  // data buffer write port
  output logic buf_we_o,
  output logic [BUF_AW-1:0] buf_addr_o,
  output logic [7:0] buf_wdata_o,
  // tag block engine, ordinary block read/write
  output logic tag_req_o,
  output logic tag_write_o,
  output logic [7:0] tag_block_o,
  output logic [5:0] tag_key_num_o,
  output logic tag_key_b_o,
  output logic tag_key_arg_o,
  output logic [47:0] tag_key_o,
  output logic [127:0] tag_wdata_o,
  input wire logic tag_done_i,
  input wire logic tag_auth_ok_i,
  input wire logic [127:0] tag_rdata_i
);

  vb_state_t state_r; // control state
  logic write_r; // current command is a value write
  logic [3:0] fetch_r; // argument fetch index
  logic [7:0] args_r [0:12]; // captured argument bytes
  logic [39:0] rd_word_r; // parsed value and address
  logic [2:0] st_cnt_r; // store byte counter
  logic [7:0] ofs_r; // buffer offset
  logic [7:0] ksel; // key selector of this command
  logic [31:0] val; // value to write
  logic [7:0] vaddr; // address byte to write
  logic [31:0] rv; // value fields of the read block
  logic [31:0] rv_inv;
  logic [31:0] rv2;
  logic [7:0] ra [0:3];
  logic parse_ok;
  logic [8:0] end_ofs;

  localparam logic [3:0] ARG_LAST = 4'hC; // selector plus six key bytes

  // argument index walks the parameter area once per read or write value command
  assign arg_addr_o = fetch_r;

  // selector and write operands from the captured arguments
  always_comb begin
    ksel = write_r ? args_r[WR_KSEL] : args_r[RD_KSEL];
    val = {args_r[WR_VAL+3], args_r[WR_VAL+2], args_r[WR_VAL+1],
           args_r[WR_VAL]};
    vaddr = args_r[WR_ADDR];
  end

  // key selection drives the block engine directly
  assign tag_key_num_o = ksel[KSEL_NUM_W-1:0];
  assign tag_key_b_o = ksel[KSEL_TYPE_BIT];
  assign tag_key_arg_o = ksel[KSEL_ARG_BIT];
  // key bytes least significant first in the argument area
  always_comb begin
    tag_key_o = '0;
    for (int i = 0; i < 6; i++) begin
      if (write_r) begin
        tag_key_o[8*i +: 8] = args_r[int'(WR_KEY) + i];
      end else begin
        tag_key_o[8*i +: 8] = args_r[int'(RD_KEY) + i];
      end
    end
  end
  assign tag_block_o = args_r[RD_BLK]; // block byte is first for both
  assign tag_write_o = write_r;
  // the request stands through the argument fetch, so key and block lines
  // still move; the engine has to hold off until they are all captured
  assign tag_req_o = (state_r == ST_ACCESS);

  // value block image: value, inverted value, value, address pattern
  always_comb begin
    tag_wdata_o = {~vaddr, vaddr, ~vaddr, vaddr,
                   val, ~val, val};
  end

  // parse the read block, all three value copies and address copies
  always_comb begin
    rv = tag_rdata_i[31:0];
    rv_inv = tag_rdata_i[63:32];
    rv2 = tag_rdata_i[95:64];
    for (int i = 0; i < 4; i++) begin
      ra[i] = tag_rdata_i[96 + 8*i +: 8];
    end
    parse_ok = (rv == rv2) && (rv == ~rv_inv) && (ra[0] == ra[2]) &&
               (ra[1] == ra[3]) && (ra[0] == ~ra[1]);
  end

  // total write span must fit in the buffer
  assign end_ofs = {1'b0, ofs_r} + 9'(RD_LEN);

  // buffer write port, byte by byte, value then address
  assign buf_we_o = (state_r == ST_STORE);
  assign buf_addr_o = BUF_AW'(ofs_r + 8'(st_cnt_r));
  assign buf_wdata_o = rd_word_r[8*st_cnt_r +: 8];
  assign cmd_busy_o = (state_r != ST_IDLE);

  // argument capture; only reads during fetch phase
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i <= 12; i++) begin
        args_r[i] <= 8'h00;
      end
    end else if (state_r == ST_ACCESS && fetch_r <= ARG_LAST) begin
      args_r[fetch_r] <= arg_data_i;
    end
  end

  // main sequencer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      write_r <= 1'b0;
      fetch_r <= 4'h0;
      st_cnt_r <= 3'h0;
      ofs_r <= 8'h00;
      rd_word_r <= '0;
      cmd_done_o <= 1'b0;
      cmd_result_o <= RES_OK;
    end else begin
      cmd_done_o <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          fetch_r <= 4'h0;
          if (cmd_start_i) begin
            if (cmd_code_i == CMD_READ_VALUE ||
                cmd_code_i == CMD_WRITE_VALUE) begin
              write_r <= (cmd_code_i == CMD_WRITE_VALUE);
              state_r <= ST_WAIT;
            end else begin
              cmd_result_o <= RES_BADCMD;
              state_r <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          // one quiet cycle so the fetch index starts from zero
          fetch_r <= 4'h0;
          state_r <= ST_ACCESS;
        end
        ST_ACCESS: begin
          // fetch then wait for the engine while request is high
          if (fetch_r <= ARG_LAST) begin
            fetch_r <= fetch_r + 4'h1;
          end
          if (fetch_r == RD_BUF_OFS) begin
            ofs_r <= arg_data_i;
          end
          if (fetch_r == ARG_LAST + 4'h1 &&
              ksel[KSEL_NUM_W-1:0] > KEY_NUM_MAX &&
              !ksel[KSEL_ARG_BIT]) begin
            cmd_result_o <= RES_BADKEY;
            state_r <= ST_DONE;
          end else if (fetch_r > ARG_LAST && tag_done_i) begin
            if (!tag_auth_ok_i) begin
              cmd_result_o <= RES_AUTH;
              state_r <= ST_DONE;
            end else if (write_r) begin
              cmd_result_o <= RES_OK;
              state_r <= ST_DONE;
            end else if (!parse_ok) begin
              cmd_result_o <= RES_PARSE;
              state_r <= ST_DONE;
            end else if (!write_r && end_ofs > (9'h001 << BUF_AW)) begin
              cmd_result_o <= RES_RANGE;
              state_r <= ST_DONE;
            end else begin
              rd_word_r <= {ra[0], rv};
              st_cnt_r <= 3'h0;
              state_r <= ST_STORE;
            end
          end
        end
        ST_STORE: begin
          if (st_cnt_r == 3'(RD_LEN - 1)) begin
            cmd_result_o <= RES_OK;
            state_r <= ST_DONE;
          end else begin
            st_cnt_r <= st_cnt_r + 3'h1;
          end
        end
        ST_DONE: begin
          cmd_done_o <= 1'b1;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

/* sim/vb_tag_model.sv */
// tag block engine model for ordinary block read and write
`timescale 1ns/1ns
module vb_tag_model (
  // clock, request and bench controls
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [127:0] wdata_i,
  input wire logic fail_i,
  input wire logic [5:0] dly_i,
  // answer
  output logic done_o,
  output logic ok_o,
  output logic [127:0] rdata_o
);
  logic [5:0] cnt_r; // cycles since the request was seen
  logic [127:0] img_r; // the one block image kept
  // answer late so the argument fetch is surely over
  always_ff @(posedge clk_i) begin
    cnt_r <= (req_i && !done_o) ? cnt_r + 6'h01 : 6'h00;
    done_o <= req_i && !done_o && cnt_r == dly_i;
    ok_o <= !fail_i;
    if (req_i && write_i && cnt_r == dly_i && !fail_i) img_r <= wdata_i;
  end
  // outside the answer the lines show garbage, not the block
  assign rdata_o = done_o ? img_r : ~img_r;
endmodule

/* sim/vb_value_props.sv */
// port assertions for the value command interpreter
`timescale 1ns/1ns
module vb_value_props
  import vb_pkg::*;
#(parameter int BUF_AW = 8) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cmd_start_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_busy_o,
  input wire logic cmd_done_o,
  input wire logic [7:0] cmd_result_o,
  input wire logic buf_we_o,
  input wire logic [BUF_AW-1:0] buf_addr_o,
  input wire logic tag_write_o,
  input wire logic [127:0] tag_wdata_o,
  input wire logic tag_done_i,
  input wire logic tag_auth_ok_i
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_store_five: assert property ($rose(buf_we_o) |->
    buf_we_o [*5] ##1 !buf_we_o) else $error("store not five bytes");
  a_addr_step: assert property (buf_we_o && $past(buf_we_o) |->
    buf_addr_o == $past(buf_addr_o) + 1'b1) else $error("buffer gap");
  a_fail_quiet: assert property (tag_done_i && !tag_auth_ok_i |=>
    !buf_we_o [*6]) else $error("write after failure");
  a_auth_code: assert property (tag_done_i && !tag_auth_ok_i &&
    !tag_write_o |-> ##[1:4] cmd_done_o && cmd_result_o == RES_AUTH)
    else $error("no auth code");
  a_write_ok: assert property (tag_done_i && tag_auth_ok_i &&
    tag_write_o |-> ##[1:4] cmd_done_o && cmd_result_o == RES_OK)
    else $error("write not ok");
  a_read_store: assert property (tag_done_i && tag_auth_ok_i &&
    !tag_write_o |=> buf_we_o || cmd_result_o == RES_PARSE ||
    cmd_result_o == RES_RANGE) else $error("read not stored");
  a_image_form: assert property (tag_done_i && tag_write_o |->
    tag_wdata_o[63:32] == ~tag_wdata_o[31:0] &&
    tag_wdata_o[95:64] == tag_wdata_o[31:0] &&
    tag_wdata_o[119:112] == tag_wdata_o[103:96] &&
    tag_wdata_o[111:104] == ~tag_wdata_o[103:96]) else $error("bad image");
  a_bad_code: assert property (cmd_start_i && !cmd_busy_o &&
    cmd_code_i != CMD_READ_VALUE && cmd_code_i != CMD_WRITE_VALUE |->
    ##[1:3] cmd_done_o && cmd_result_o == RES_BADCMD) else $error("code");
endmodule
bind vb_value_cmd vb_value_props #(.BUF_AW(BUF_AW)) u_props (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_start_i(cmd_start_i),
  .cmd_code_i(cmd_code_i), .cmd_busy_o(cmd_busy_o),
  .cmd_done_o(cmd_done_o), .cmd_result_o(cmd_result_o),
  .buf_we_o(buf_we_o), .buf_addr_o(buf_addr_o),
  .tag_write_o(tag_write_o), .tag_wdata_o(tag_wdata_o),
  .tag_done_i(tag_done_i), .tag_auth_ok_i(tag_auth_ok_i));

/* sim/tb.sv */
// self-checking bench for the value command interpreter
`timescale 1ns/1ns
module tb;
  import vb_pkg::*;
  logic core_clk_i = 0, rst_i = 1, cmd_start_i = 0, fail = 0;
  logic [7:0] cmd_code_i = 8'h00, cmd_result_o, arg_data_i, buf_wdata_o;
  logic [7:0] buf_addr_o, tag_block_o;
  logic [3:0] arg_addr_o;
  logic cmd_busy_o, cmd_done_o, buf_we_o, tag_req_o, tag_write_o;
  logic tag_key_b_o, tag_key_arg_o, tag_done_i, tag_auth_ok_i;
  logic [5:0] tag_key_num_o, dly = 6'h0E;
  logic [47:0] tag_key_o;
  logic [127:0] tag_wdata_o, tag_rdata_i;
  logic [7:0] args [16]; // parameter area
  logic [16:0] q [$]; // expected buffer writes and results
  logic [63:0] exp_tag, tag_sel; // expected and seen key choice, block
  int errors = 0, tests_run = 0;
  assign arg_data_i = args[arg_addr_o];
  assign tag_sel = {tag_key_arg_o, tag_key_b_o, tag_key_num_o, tag_key_o,
    tag_block_o};
  vb_value_cmd uut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cmd_start_i(cmd_start_i), .cmd_code_i(cmd_code_i),
    .cmd_busy_o(cmd_busy_o), .cmd_done_o(cmd_done_o),
    .cmd_result_o(cmd_result_o), .arg_addr_o(arg_addr_o),
    .arg_data_i(arg_data_i), .buf_we_o(buf_we_o), .buf_addr_o(buf_addr_o),
    .buf_wdata_o(buf_wdata_o), .tag_req_o(tag_req_o),
    .tag_write_o(tag_write_o), .tag_block_o(tag_block_o),
    .tag_key_num_o(tag_key_num_o), .tag_key_b_o(tag_key_b_o),
    .tag_key_arg_o(tag_key_arg_o), .tag_key_o(tag_key_o),
    .tag_wdata_o(tag_wdata_o), .tag_done_i(tag_done_i),
    .tag_auth_ok_i(tag_auth_ok_i), .tag_rdata_i(tag_rdata_i));
  vb_tag_model tm (.clk_i(core_clk_i), .req_i(tag_req_o),
    .write_i(tag_write_o), .wdata_i(tag_wdata_o), .fail_i(fail),
    .dly_i(dly), .done_o(tag_done_i), .ok_o(tag_auth_ok_i),
    .rdata_o(tag_rdata_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    if (q.size() != 0) errors++; // a note left over means a missed result
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one command: pulse start, then wait bounded for idle
  task automatic run(input logic [7:0] code);
    int i;
    @(negedge core_clk_i);
    cmd_code_i = code;
    cmd_start_i = 1;
    @(negedge core_clk_i);
    cmd_start_i = 0;
    for (i = 0; i < 200 && cmd_busy_o !== 1'b0; i++) @(negedge core_clk_i);
    if (i == 200) errors++;
  endtask
  // watcher pairs each result with the oldest note
  always @(posedge core_clk_i) begin
    if (buf_we_o) check({buf_addr_o, buf_wdata_o}, q.pop_front());
    if (cmd_done_o) check({9'h100, cmd_result_o}, q.pop_front());
    if (tag_done_i) check(tag_sel, exp_tag);
  end
  initial begin
    logic [31:0] v;
    logic [7:0] a, ofs, ks, blk;
    logic [47:0] k;
    int r, j;
    void'($urandom(32'h1711e4b1));
    for (j = 0; j < 16; j++) args[j] = 8'h00;
    repeat (5) @(negedge core_clk_i);
    rst_i = 0;
    q.push_back({9'h100, RES_BADCMD});
    run(8'h0C);
    for (r = 0; r < 6; r++) begin
      v = $urandom;
      a = 8'($urandom);
      blk = 8'($urandom);
      k = 48'({$urandom, $urandom});
      ofs = (r == 1) ? 8'hFB : (r == 4) ? 8'hFC : 8'($urandom_range(250));
      ks = {r[0], 1'b1, 6'($urandom_range(39))};
      dly = 6'h0E + 6'(r * 9);
      // write arguments, key least byte first
      args[WR_BLK] = blk;
      {args[4], args[3], args[2], args[1]} = v;
      args[WR_ADDR] = a;
      args[WR_KSEL] = ks;
      for (j = 0; j < 6; j++) args[WR_KEY + j] = k[8*j +: 8];
      exp_tag = {ks[6], ks[7], ks[5:0], k, blk};
      q.push_back({9'h100, RES_OK});
      run(CMD_WRITE_VALUE);
      args[RD_BLK] = blk;
      args[RD_BUF_OFS] = ofs;
      args[RD_KSEL] = ks;
      for (j = 0; j < 6; j++) args[RD_KEY + j] = k[8*j +: 8];
      fail = (r == 5);
      // value least byte first, address byte after it
      if (r < 4) for (j = 0; j < 5; j++)
        q.push_back({ofs + 8'(j), j < 4 ? v[8*j +: 8] : a});
      q.push_back({9'h100, r == 5 ? RES_AUTH : r == 4 ? RES_RANGE : RES_OK});
      run(CMD_READ_VALUE);
      fail = 0;
    end
    // stored key 39, the last legal number, with the second key type
    args[WR_KSEL] = 8'hA7;
    for (j = 0; j < 6; j++) k[8*j +: 8] = args[WR_KEY + j];
    exp_tag = {2'b01, 6'h27, k, args[WR_BLK]};
    q.push_back({9'h100, RES_OK});
    run(CMD_WRITE_VALUE);
    args[WR_KSEL] = 8'h28; // stored key number past the last
    q.push_back({9'h100, RES_BADKEY});
    run(CMD_WRITE_VALUE);
    // let the watcher see the last done pulse before closing
    repeat (2) @(negedge core_clk_i);
    conclude();
  end
  initial begin
    #60000;
    errors++;
    conclude();
  end
endmodule
